/* dv/pci_far_agent.sv */
// Far PCI agent driving the shared address, command and parity lines
`timescale 1ns/1ps
module pci_far_agent (
    // Clock and request
    input  wire logic        clock_i,
    input  wire logic        req_i,
    input  wire logic [31:0] req_ad_i,
    input  wire logic [3:0]  req_cbe_i,
    input  wire logic        req_addr_i,
    input  wire logic        req_bad_i,
    // Bus lines
    output logic      [31:0] ad_o,
    output logic      [3:0]  cbe_n_o,
    output logic             par_o,
    output logic             addr_phase_o,
    output logic             data_phase_o
);
    logic bad_ff;
    initial {ad_o, cbe_n_o, par_o, addr_phase_o, data_phase_o, bad_ff} = '0;
    always @(negedge clock_i) begin
        // Parity trails its phase by one clock
        par_o <= ^{ad_o, cbe_n_o} ^ bad_ff;
        bad_ff <= req_i && req_bad_i;
        addr_phase_o <= req_i && req_addr_i;
        data_phase_o <= req_i && !req_addr_i;
        // Released lines keep changing
        ad_o <= req_i ? req_ad_i : ~ad_o;
        cbe_n_o <= req_i ? req_cbe_i : ~cbe_n_o;
    end
endmodule : pci_far_agent

/* dv/pci_par_chk.sv */
// Assertion checker for the parity and interrupt steering block
`timescale 1ns/1ps
module pci_par_chk (
    // Watched ports
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  cfg_addr_i,
    input wire logic [15:0] cfg_wdata_i,
    input wire logic [1:0]  cfg_be_i,
    input wire logic        cfg_wr_i,
    input wire logic [31:0] ad_i,
    input wire logic [3:0]  cbe_n_i,
    input wire logic        par_i,
    input wire logic        addr_phase_i,
    input wire logic        data_phase_i,
    input wire logic        is_master_i,
    input wire logic        is_write_i,
    input wire logic        perr_n_i,
    input wire logic        buf_not_empty_i,
    input wire logic        par_o,
    input wire logic        par_oe_o,
    input wire logic        perr_n_o,
    input wire logic        perr_oe_o,
    input wire logic        serr_n_o,
    input wire logic        serr_oe_o,
    input wire logic        delayed_en_o,
    input wire logic        retry_allowed_o,
    input wire logic [15:0] routed_pci_irq_line_o
);
    logic pe_ff, f2_ff, f3_ff, sh_ff, drv_ff, dck_ff, ack_ff, pexp_ff;
    wire  wr0  = cfg_wr_i && cfg_be_i[0];
    wire  derr = dck_ff && (par_i != pexp_ff);
    wire  aerr = ack_ff && (par_i != pexp_ff);
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            {pe_ff, f2_ff, f3_ff, sh_ff} <= 4'h3;
            {drv_ff, dck_ff, ack_ff} <= 3'h0;
        end else begin
            if (wr0 && cfg_addr_i == 8'h04) pe_ff <= cfg_wdata_i[6];
            if (wr0 && cfg_addr_i == 8'h41) f2_ff <= cfg_wdata_i[5];
            if (wr0 && cfg_addr_i == 8'h42) f3_ff <= cfg_wdata_i[5];
            if (wr0 && cfg_addr_i == 8'h43) sh_ff <= cfg_wdata_i[1];
            drv_ff <= is_master_i && (addr_phase_i || (data_phase_i && is_write_i));
            dck_ff <= pe_ff && data_phase_i && (is_master_i != is_write_i);
            ack_ff <= pe_ff && addr_phase_i && !is_master_i;
        end
        pexp_ff <= ^{ad_i, cbe_n_i};
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_par_value: assert property (par_oe_o |-> par_o == pexp_ff)
        else $error("parity output wrong");
    a_par_drive: assert property (par_oe_o == drv_ff)
        else $error("parity drive window wrong");
    a_perr_match: assert property (1'b1 |=> perr_oe_o == $past(derr))
        else $error("error line does not follow data check");
    a_perr_level: assert property (perr_oe_o |-> !perr_n_o)
        else $error("error line driven high");
    a_serr_src: assert property ((derr && f2_ff) || aerr |=> serr_oe_o)
        else $error("system error not driven");
    a_delay_gate: assert property (delayed_en_o == f3_ff)
        else $error("delayed enable wrong");
    a_retry_gate: assert property (retry_allowed_o == (!buf_not_empty_i || sh_ff))
        else $error("retry permission wrong");
    a_rsvd_quiet: assert property ((routed_pci_irq_line_o & 16'h2105) == 16'h0000)
        else $error("reserved interrupt number driven");
    a_master_serr: assert property ((!perr_n_i ##2 is_master_i) |=> serr_oe_o)
        else $error("system error not raised on target error report");
    a_serr_level: assert property (serr_oe_o |-> !serr_n_o)
        else $error("system error line driven high");
endmodule : pci_par_chk
bind pci_parity_irq_steering pci_par_chk u_chk (.*);

/* dv/tb_pci_parity_irq_steering.sv */
// Self-checking bench for the parity and interrupt steering block
`timescale 1ns/1ps
module tb_pci_parity_irq_steering;
    logic        clock_i, rst_n_i, cfg_wr_i, par_i, addr_phase_i, data_phase_i;
    logic        is_master_i, is_write_i, perr_n_i, buf_not_empty_i, par_o, par_oe_o;
    logic        perr_n_o, perr_oe_o, serr_n_o, serr_oe_o, delayed_en_o, retry_allowed_o;
    logic [7:0]  cfg_addr_i;
    logic [15:0] cfg_wdata_i, cfg_rdata_o, routed_pci_irq_line_o, ev;
    logic [1:0]  cfg_be_i;
    logic [31:0] ad_i, rad, rnd;
    logic [3:0]  cbe_n_i, rcbe, pci_int_n_i;
    logic        req, req_addr, req_bad, look_rd, look_irq;
    logic [15:0] rd_q[$], msk_q[$], irq_q[$];
    int          bad_count, checks_done;
    logic [7:0]  offs[8] = '{8'h04, 8'h06, 8'h41, 8'h42, 8'h43, 8'h5c, 8'h5d, 8'h10};
    logic [15:0] rstv[8] = '{16'h0000, 16'h0280, 16'h0010, 16'h00ac,
                             16'h0003, 16'h0000, 16'h0000, 16'h0000};
    pci_parity_irq_steering uut (.*);
    pci_far_agent u_far (.clock_i(clock_i), .req_i(req), .req_ad_i(rad), .req_cbe_i(rcbe),
        .req_addr_i(req_addr), .req_bad_i(req_bad), .ad_o(ad_i), .cbe_n_o(cbe_n_i),
        .par_o(par_i), .addr_phase_o(addr_phase_i), .data_phase_o(data_phase_i));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic chk_irq(input logic [15:0] e, input logic [15:0] g);
        chk("routed interrupts", e, g);
    endtask : chk_irq
    task automatic close_out;
        if (bad_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
        @(negedge clock_i);
        {cfg_addr_i, cfg_wdata_i, cfg_be_i, cfg_wr_i} = {a, d, b, 1'b1};
        @(negedge clock_i);
        cfg_wr_i = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        @(negedge clock_i);
        cfg_addr_i = a;
        @(negedge clock_i);
        rd_q.push_back(e);
        msk_q.push_back(m);
        look_rd = 1'b1;
        @(negedge clock_i);
        look_rd = 1'b0;
    endtask : rd_reg
    task automatic phase(input logic a, input logic m, input logic w, input logic b);
        @(negedge clock_i);
        {is_master_i, is_write_i} = {m, w};
        @(posedge clock_i);
        {req, rad, rcbe, req_addr, req_bad} <= {1'b1, rnd, rnd[7:4], a, b};
        @(posedge clock_i);
        req <= 1'b0;
        repeat (5) @(posedge clock_i);
    endtask : phase
    always @(posedge clock_i) begin
        if (look_rd) chk("register read", rd_q.pop_front(), cfg_rdata_o & msk_q.pop_front());
        if (look_irq) chk_irq(irq_q.pop_front(), routed_pci_irq_line_o);
    end
    always @(negedge clock_i) begin
        rnd <= lfsr(rnd);
        buf_not_empty_i <= rnd[5];
    end
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    initial begin
        repeat (5000) @(posedge clock_i);
        bad_count++;
        close_out();
    end
    initial begin
        {rst_n_i, cfg_wr_i, cfg_addr_i, cfg_wdata_i, cfg_be_i, req, rad, rcbe} = '0;
        {req_addr, req_bad, is_master_i, is_write_i, look_rd, look_irq} = '0;
        {perr_n_i, pci_int_n_i, buf_not_empty_i, rnd} = {1'b1, 4'hf, 1'b0, 32'h0001_0396};
        {bad_count, checks_done} = '0;
        repeat (4) @(negedge clock_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 8; i++) rd_reg(offs[i], rstv[i], i < 2 ? 16'hffff : 16'h00ff);
        wr_reg(8'h04, 16'hffff, 2'h3);
        rd_reg(8'h04, 16'h015f, 16'hffff);
        wr_reg(8'h04, 16'h0000, 2'h3);
        phase(1'b0, 1'b0, 1'b1, 1'b1);
        rd_reg(8'h06, 16'h0280, 16'hffff);
        wr_reg(8'h04, 16'h0040, 2'h3);
        phase(1'b0, 1'b0, 1'b1, 1'b1);
        rd_reg(8'h06, 16'h8280, 16'hffff);
        wr_reg(8'h06, 16'h8000, 2'h3);
        rd_reg(8'h06, 16'h0280, 16'hffff);
        wr_reg(8'h41, 16'h0030, 2'h1);
        phase(1'b0, 1'b1, 1'b0, 1'b1);
        rd_reg(8'h06, 16'hc280, 16'hffff);
        wr_reg(8'h06, 16'hc000, 2'h3);
        phase(1'b0, 1'b1, 1'b1, 1'b1);
        rd_reg(8'h06, 16'h0280, 16'hffff);
        phase(1'b1, 1'b0, 1'b0, 1'b1);
        rd_reg(8'h06, 16'hc280, 16'hffff);
        wr_reg(8'h06, 16'hc000, 2'h3);
        {is_master_i, perr_n_i} = 2'b10;
        repeat (3) @(negedge clock_i);
        perr_n_i = 1'b1;
        repeat (4) @(negedge clock_i);
        rd_reg(8'h06, 16'h4000, 16'h4000);
        wr_reg(8'h42, 16'h008c, 2'h1);
        rd_reg(8'h42, 16'h008c, 16'h00ff);
        wr_reg(8'h43, 16'h0001, 2'h1);
        repeat (12) @(negedge clock_i);
        for (int c = 0; c < 16; c++) begin
            wr_reg(c[1] ? 8'h5d : 8'h5c,
                   c[0] ? {8'h00, c[3:0], 4'h1} : {8'h00, 4'h1, c[3:0]}, 2'h1);
            ev = (c == 0 || c == 2 || c == 8 || c == 13) ? 16'h0000 : 16'h0001 << c;
            pci_int_n_i = ~(4'h1 << c[1:0]);
            repeat (4) @(negedge clock_i);
            irq_q.push_back(ev);
            look_irq = 1'b1;
            @(negedge clock_i);
            {look_irq, pci_int_n_i} = {1'b0, 4'hf};
            repeat (4) @(negedge clock_i);
        end
        // Mid-run reset must restore every register
        wr_reg(8'h5c, 16'h00ff, 2'h1);
        rst_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 8; i++) rd_reg(offs[i], rstv[i], i < 2 ? 16'hffff : 16'h00ff);
        close_out();
    end
endmodule : tb_pci_parity_irq_steering

/* rtl/irq_route.sv */
// One PCI interrupt line steered onto a one-hot legacy IRQ vector
`timescale 1ns/1ps
module irq_route (
    // Steering field and line
    input  wire logic [3:0]  code_i,
    input  wire logic        line_i,
    // Routed vector
    output logic      [15:0] irq_vec_o
);
    logic code_ok;

    assign code_ok   = (code_i != pci_par_pkg::IRQ_CODE_DISABLE) &&
                       (code_i != pci_par_pkg::IRQ_CODE_RSVD_A) &&
                       (code_i != pci_par_pkg::IRQ_CODE_RSVD_B) &&
                       (code_i != pci_par_pkg::IRQ_CODE_RSVD_C);
    assign irq_vec_o = (code_ok && line_i) ? (16'h0001 << code_i) : 16'h0000;
endmodule : irq_route

/* rtl/pci_par_pkg.sv */
// Constants shared by the parity and interrupt steering block
package pci_par_pkg;
    // ****************************************
    // Register offsets (configuration index)
    // ****************************************
    localparam logic [7:0] OFF_PCI_COMMAND     = 8'h04;
    localparam logic [7:0] OFF_PCI_STATUS      = 8'h06;
    localparam logic [7:0] OFF_FUNC_CTRL_TWO   = 8'h41;
    localparam logic [7:0] OFF_FUNC_CTRL_THREE = 8'h42;
    localparam logic [7:0] OFF_RETRY_SHADOW    = 8'h43;
    localparam logic [7:0] OFF_IRQ_STEER_AB    = 8'h5c;
    localparam logic [7:0] OFF_IRQ_STEER_CD    = 8'h5d;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] RST_PCI_COMMAND     = 16'h0000;
    localparam logic [15:0] RST_PCI_STATUS      = 16'h0280;
    localparam logic [7:0]  RST_FUNC_CTRL_TWO   = 8'h10;
    localparam logic [7:0]  RST_FUNC_CTRL_THREE = 8'hac;
    localparam logic [7:0]  RST_RETRY_SHADOW    = 8'h03;
    localparam logic [7:0]  RST_IRQ_STEER       = 8'h00;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CMD_PARITY_EN_BIT   = 6;
    localparam int STS_DET_PAR_BIT     = 15;
    localparam int STS_SIG_SERR_BIT    = 14;
    localparam int FC2_PERR_SERR_BIT   = 5;
    localparam int FC3_DELAYED_BIT     = 5;
    localparam int SHADOW_RETRY_BIT    = 1;
    localparam int STEER_LO_LSB        = 0;
    localparam int STEER_HI_LSB        = 4;
    localparam int STEER_FIELD_W       = 4;
    // ****************************************
    // Steering codes
    // ****************************************
    localparam logic [3:0] IRQ_CODE_DISABLE = 4'h0;
    localparam logic [3:0] IRQ_CODE_RSVD_A  = 4'h2;
    localparam logic [3:0] IRQ_CODE_RSVD_B  = 4'h8;
    localparam logic [3:0] IRQ_CODE_RSVD_C  = 4'hd;
endpackage : pci_par_pkg

/* rtl/pci_parity_irq_steering.sv */
// Parity generation and checking, error reporting, IRQ steering, retry gating
`timescale 1ns/1ps
// Summary of operation
// - PAR is even parity over AD[31:0] and the four C/BE lines.
// - As initiator drive address parity always, data parity on writes, check reads.
// - Data parity errors detected and PERR driven only with command bit 6 set.
// - Data parity error also drives SERR when function control two bit 5 set.
// - Address parity errors checked with command bit 6 and raise SERR internally.
// - As master, sampling PERR from the target raises SERR internally.
// - Status bit 15 sets on a parity error only with command bit 6 set, or on PERR sampled as master, cleared by writing one.
// - Status bit 14 sets whenever SERR is driven, cleared by writing one.
// - Delayed transactions allowed only with function control three bit 5.
// - Target retry with nonempty buffer allowed only with shadow bit 1.
module pci_parity_irq_steering (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Configuration register port
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [15:0] cfg_wdata_i,
    input  wire logic [1:0]  cfg_be_i,
    input  wire logic        cfg_wr_i,
    output logic      [15:0] cfg_rdata_o,
    // PCI bus
    input  wire logic [31:0] ad_i,
    input  wire logic [3:0]  cbe_n_i,
    input  wire logic        par_i,
    input  wire logic        addr_phase_i,
    input  wire logic        data_phase_i,
    input  wire logic        is_master_i,
    input  wire logic        is_write_i,
    input  wire logic        perr_n_i,
    output logic             par_o,
    output logic             par_oe_o,
    output logic             perr_n_o,
    output logic             perr_oe_o,
    output logic             serr_n_o,
    output logic             serr_oe_o,
    // Transaction gating
    input  wire logic        buf_not_empty_i,
    output logic             delayed_en_o,
    output logic             retry_allowed_o,
    // Interrupts
    input  wire logic [3:0]  pci_int_n_i,
    output logic      [15:0] routed_pci_irq_line_o
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [3:0]  int_meta_ff;
    logic [3:0]  int_sync_ff;
    logic        perr_meta_ff;
    logic        perr_sync_ff;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            int_meta_ff  <= 4'hf;
            int_sync_ff  <= 4'hf;
            perr_meta_ff <= 1'b1;
            perr_sync_ff <= 1'b1;
        end else begin
            int_meta_ff  <= pci_int_n_i;
            int_sync_ff  <= int_meta_ff;
            perr_meta_ff <= perr_n_i;
            perr_sync_ff <= perr_meta_ff;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    logic [15:0] command_ff;
    logic [15:0] status_ff;
    logic [7:0]  fc_two_ff;
    logic [7:0]  fc_three_ff;
    logic [7:0]  shadow_ff;
    logic [7:0]  steer_ab_ff;
    logic [7:0]  steer_cd_ff;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = cfg_wr_i && (a == off);
    endfunction : hit

    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [15:0] wd,
                                          input logic be);
        merge8 = be ? wd[7:0] : old;
    endfunction : merge8

    logic [15:0] be_mask;
    logic [15:0] cmd_wmask;
    assign be_mask   = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
    assign cmd_wmask = be_mask & 16'h015f;

    // ****************************************
    // Parity
    // ****************************************
    logic par_calc;
    logic par_err;
    logic chk_en;
    logic addr_par_err;
    logic data_par_err;
    logic drive_par;
    logic par_phase_ff;
    logic par_out_ff;
    logic check_data_ff;
    logic check_addr_ff;

    assign par_calc  = ^{ad_i, cbe_n_i};
    assign chk_en    = command_ff[pci_par_pkg::CMD_PARITY_EN_BIT];
    assign drive_par = is_master_i && (addr_phase_i || (data_phase_i && is_write_i));

    // Parity trails its phase by one clock on PCI
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            par_phase_ff  <= 1'b0;
            par_out_ff    <= 1'b0;
            check_data_ff <= 1'b0;
            check_addr_ff <= 1'b0;
        end else begin
            par_phase_ff  <= drive_par;
            par_out_ff    <= par_calc;
            check_data_ff <= data_phase_i && (is_master_i ? !is_write_i : is_write_i);
            check_addr_ff <= addr_phase_i && !is_master_i;
        end
    end

    logic [35:0] held_bits_ff;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            held_bits_ff <= 36'h000000000;
        end else begin
            held_bits_ff <= {ad_i, cbe_n_i};
        end
    end

    assign par_err      = (^held_bits_ff) != par_i;
    assign data_par_err = chk_en && check_data_ff && par_err;
    assign addr_par_err = chk_en && check_addr_ff && par_err;

    logic master_perr;
    assign master_perr = is_master_i && !perr_sync_ff;

    logic serr_evt;
    assign serr_evt = addr_par_err || master_perr ||
                      (data_par_err && fc_two_ff[pci_par_pkg::FC2_PERR_SERR_BIT]);

    logic perr_drv_ff;
    logic serr_drv_ff;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            perr_drv_ff <= 1'b0;
            serr_drv_ff <= 1'b0;
        end else begin
            perr_drv_ff <= data_par_err;
            serr_drv_ff <= serr_evt;
        end
    end

    assign par_o     = par_out_ff;
    assign par_oe_o  = par_phase_ff;
    assign perr_n_o  = !perr_drv_ff;
    assign perr_oe_o = perr_drv_ff;
    assign serr_n_o  = 1'b0;
    assign serr_oe_o = serr_drv_ff;

    // ****************************************
    // Register writes
    // ****************************************
    logic [15:0] sts_w1c;
    logic [15:0] sts_set;
    assign sts_w1c = hit(cfg_addr_i, pci_par_pkg::OFF_PCI_STATUS) ? (cfg_wdata_i & be_mask)
                                                                   : 16'h0000;
    assign sts_set = {(data_par_err || addr_par_err || master_perr),
                      serr_drv_ff, 14'h0000};

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            command_ff  <= pci_par_pkg::RST_PCI_COMMAND;
            status_ff   <= pci_par_pkg::RST_PCI_STATUS;
            fc_two_ff   <= pci_par_pkg::RST_FUNC_CTRL_TWO;
            fc_three_ff <= pci_par_pkg::RST_FUNC_CTRL_THREE;
            shadow_ff   <= pci_par_pkg::RST_RETRY_SHADOW;
            steer_ab_ff <= pci_par_pkg::RST_IRQ_STEER;
            steer_cd_ff <= pci_par_pkg::RST_IRQ_STEER;
        end else begin
            if (hit(cfg_addr_i, pci_par_pkg::OFF_PCI_COMMAND)) begin
                command_ff <= (command_ff & ~cmd_wmask) | (cfg_wdata_i & cmd_wmask);
            end
            // Set wins over a same-cycle clear
            status_ff[pci_par_pkg::STS_DET_PAR_BIT] <=
                sts_set[15] | (status_ff[15] & ~sts_w1c[15]);
            status_ff[pci_par_pkg::STS_SIG_SERR_BIT] <=
                sts_set[14] | (status_ff[14] & ~sts_w1c[14]);
            if (hit(cfg_addr_i, pci_par_pkg::OFF_FUNC_CTRL_TWO)) begin
                fc_two_ff <= merge8(fc_two_ff, cfg_wdata_i, cfg_be_i[0]);
            end
            if (hit(cfg_addr_i, pci_par_pkg::OFF_FUNC_CTRL_THREE)) begin
                fc_three_ff <= merge8(fc_three_ff, cfg_wdata_i, cfg_be_i[0]);
            end
            if (hit(cfg_addr_i, pci_par_pkg::OFF_RETRY_SHADOW)) begin
                shadow_ff <= merge8(shadow_ff, cfg_wdata_i, cfg_be_i[0]);
            end
            if (hit(cfg_addr_i, pci_par_pkg::OFF_IRQ_STEER_AB)) begin
                steer_ab_ff <= merge8(steer_ab_ff, cfg_wdata_i, cfg_be_i[0]);
            end
            if (hit(cfg_addr_i, pci_par_pkg::OFF_IRQ_STEER_CD)) begin
                steer_cd_ff <= merge8(steer_cd_ff, cfg_wdata_i, cfg_be_i[0]);
            end
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    logic [15:0] rdata_nxt;
    always_comb begin
        case (cfg_addr_i)
            pci_par_pkg::OFF_PCI_COMMAND:     rdata_nxt = command_ff;
            pci_par_pkg::OFF_PCI_STATUS:      rdata_nxt = status_ff;
            pci_par_pkg::OFF_FUNC_CTRL_TWO:   rdata_nxt = {8'h00, fc_two_ff};
            pci_par_pkg::OFF_FUNC_CTRL_THREE: rdata_nxt = {8'h00, fc_three_ff};
            pci_par_pkg::OFF_RETRY_SHADOW:    rdata_nxt = {8'h00, shadow_ff};
            pci_par_pkg::OFF_IRQ_STEER_AB:    rdata_nxt = {8'h00, steer_ab_ff};
            pci_par_pkg::OFF_IRQ_STEER_CD:    rdata_nxt = {8'h00, steer_cd_ff};
            default:                          rdata_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cfg_rdata_o <= 16'h0000;
        end else begin
            cfg_rdata_o <= rdata_nxt;
        end
    end

    // ****************************************
    // Transaction gating
    // ****************************************
    assign delayed_en_o    = fc_three_ff[pci_par_pkg::FC3_DELAYED_BIT];
    assign retry_allowed_o = !buf_not_empty_i ||
                             shadow_ff[pci_par_pkg::SHADOW_RETRY_BIT];

    // ****************************************
    // Interrupt steering
    // ****************************************
    logic [15:0] codes;
    logic [15:0] vecs [4];
    assign codes = {steer_cd_ff, steer_ab_ff};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_route
            irq_route u_route (
                .code_i    (codes[gi*4 +: 4]),
                .line_i    (!int_sync_ff[gi]),
                .irq_vec_o (vecs[gi])
            );
        end
    endgenerate

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            routed_pci_irq_line_o <= 16'h0000;
        end else begin
            routed_pci_irq_line_o <= vecs[0] | vecs[1] | vecs[2] | vecs[3];
        end
    end
endmodule : pci_parity_irq_steering
